// [verilog/pwm_timebase_event_blanking.sv]
// time base, event sources, flags and input blanking of a pwm controller
// =============================================================
`timescale 1ns/1ps
`default_nettype none
module pwm_timebase_event_blanking
	import timebase_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire cfg_t cfg_i,
	input wire logic sleep_i,
	input wire logic fast_osc_i,
	input wire logic ext_clk_i,
	input wire logic external_event_pin_i,
	input wire logic [3:0] comparator_synced_out_i,
	input wire logic value_wr_i,
	input wire logic [2:0] value_sel_i,
	input wire logic [7:0] value_byte_i,
	input wire logic buffer_load_request_i,
	input wire logic [3:0] flag_set_i,
	input wire logic [3:0] flag_clr_i,
	input wire logic summary_clr_i,
	input wire logic timebase_summary_enable_i,
	input wire logic peripheral_global_enable_i,
	input wire logic global_irq_enable_i,
	output logic [15:0] timebase_counter_o,
	output match_values_t staged_values_o,
	output logic buffer_load_request_o,
	output logic period_event_o,
	output logic rising_event_o,
	output logic falling_event_o,
	output logic pwm_active_o,
	output logic shutdown_request_o,
	output logic [1:0] blanking_o,
	output logic [3:0] irq_flags_o,
	output logic timebase_summary_flag_o,
	output logic irq_o
);

	// =========================================================
	// input synchronisers and clock source selection
	logic [2:0] fast_sync_reg, ext_sync_reg;
	logic [1:0] pin_sync_reg;
	logic src_tick, tick;
	logic [2:0] div_cnt_reg, div_mask;

	// pin and foreign clocks pass two flops; bit 2 is only an edge history
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			fast_sync_reg <= 3'h0;
			ext_sync_reg <= 3'h0;
			pin_sync_reg <= 2'h0;
		end else begin
			fast_sync_reg <= {fast_sync_reg[1:0], fast_osc_i};
			ext_sync_reg <= {ext_sync_reg[1:0], ext_clk_i};
			pin_sync_reg <= {pin_sync_reg[0], external_event_pin_i};
		end
	end

	// system source stops in sleep, the fast source keeps going
	always_comb begin
		case (cfg_i.clock_source_select)
			CSRC_SYSOSC: src_tick = !sleep_i;
			CSRC_FAST: src_tick = fast_sync_reg[1] && !fast_sync_reg[2];
			CSRC_EXTPIN: src_tick = ext_sync_reg[1] && !ext_sync_reg[2];
			default: src_tick = 1'b0;
		endcase
		case (cfg_i.clock_divide_select)
			2'h0: div_mask = 3'h0;
			2'h1: div_mask = 3'h1;
			2'h2: div_mask = 3'h3;
			default: div_mask = 3'h7;
		endcase
	end
	assign tick = src_tick && ((div_cnt_reg & div_mask) == div_mask);

	// prescaler free-runs even while disabled so the clock keeps going
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			div_cnt_reg <= DIV_RESET;
		end else if (src_tick) begin
			div_cnt_reg <= div_cnt_reg + 3'h1;
		end
	end

	// =========================================================
	// asynchronous event inputs, polarity and blanking
	logic en;
	logic [15:0] counter_reg;
	match_values_t staged_reg, active_reg;
	logic [4:0] async_raw, blank_mask, per_lvl, rise_lvl, fall_lvl;
	logic [4:0] per_prev_reg, rise_prev_reg, fall_prev_reg;
	logic async_per, async_rise, async_fall;
	logic per_match, ph_match, dc_match;
	logic per_ev, rise_ev, fall_ev, ovf_ev;
	logic rise_done_reg, fall_done_reg, load_pending_reg;
	logic [1:0] blank_on;
	logic [3:0] flags_reg, hw_flags;

	assign en = cfg_i.module_enable_bit;
	assign async_raw = {pin_sync_reg[1], comparator_synced_out_i};
	// blanked inputs are forced inactive after polarity is applied
	assign blank_mask = (blank_on[0] ? cfg_i.rising_blank_sources : 5'h00)
		| (blank_on[1] ? cfg_i.falling_blank_sources : 5'h00);
	assign per_lvl = (async_raw ^ {5{cfg_i.period_async_invert}})
		& ~blank_mask;
	assign rise_lvl = async_raw & ~blank_mask;
	assign fall_lvl = (async_raw ^ {5{cfg_i.falling_async_invert}})
		& ~blank_mask;

	// edge history moves at the module tick; levels never retrigger
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			per_prev_reg <= 5'h00;
			rise_prev_reg <= 5'h00;
			fall_prev_reg <= 5'h00;
		end else if (tick) begin
			per_prev_reg <= per_lvl;
			rise_prev_reg <= rise_lvl;
			fall_prev_reg <= fall_lvl;
		end
	end
	assign async_per = |(per_lvl & ~per_prev_reg
		& cfg_i.period_sources[5:1]);
	assign async_rise = |(rise_lvl & ~rise_prev_reg
		& cfg_i.rising_sources[5:1]);
	assign async_fall = |(fall_lvl & ~fall_prev_reg
		& cfg_i.falling_sources[5:1]);

	// =========================================================
	// synchronous matches and the three events
	assign per_match = tick && en && counter_reg == active_reg.period;
	assign ph_match = tick && en && counter_reg == active_reg.phase;
	assign dc_match = tick && en && counter_reg == active_reg.duty;
	assign per_ev = tick && en && ((per_match
		&& cfg_i.period_sources[SRC_TIMEBASE]) || async_per);
	// a fall in this period blocks any later rise
	assign rise_ev = tick && en && !rise_done_reg && !fall_done_reg
		&& ((ph_match && cfg_i.rising_sources[SRC_TIMEBASE])
		|| async_rise);
	assign fall_ev = tick && en && !fall_done_reg
		&& ((dc_match && cfg_i.falling_sources[SRC_TIMEBASE])
		|| async_fall);
	assign ovf_ev = tick && en && counter_reg == COUNTER_MAX && !per_ev;

	// counter: 0..period then back to zero gives period+1 ticks
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			counter_reg <= COUNTER_RESET;
		end else if (!en) begin
			counter_reg <= COUNTER_RESET;
		end else if (tick) begin
			counter_reg <= per_ev ? COUNTER_RESET
				: counter_reg + 16'h0001;
		end
	end

	// once-per-period bookkeeping and the active drive level
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			rise_done_reg <= 1'b0;
			fall_done_reg <= 1'b0;
			pwm_active_o <= 1'b0;
		end else if (!en) begin
			rise_done_reg <= 1'b0;
			fall_done_reg <= 1'b0;
			pwm_active_o <= 1'b0;
		end else if (tick) begin
			rise_done_reg <= per_ev ? 1'b0 : (rise_done_reg || rise_ev);
			fall_done_reg <= per_ev ? 1'b0 : (fall_done_reg || fall_ev);
			// fall wins over a coincident rise: zero duty
			if (fall_ev) begin
				pwm_active_o <= 1'b0;
			end else if (rise_ev) begin
				pwm_active_o <= 1'b1;
			end
		end
	end

	// one-cycle event pulses and level shutdown request
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			period_event_o <= 1'b0;
			rising_event_o <= 1'b0;
			falling_event_o <= 1'b0;
			shutdown_request_o <= 1'b0;
		end else begin
			period_event_o <= per_ev;
			rising_event_o <= rise_ev;
			falling_event_o <= fall_ev;
			shutdown_request_o <= en && |(async_raw & ~blank_mask
				& cfg_i.shutdown_sources);
		end
	end

	// =========================================================
	// blanking counters, one per edge
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_blank
			blank_state_t state_reg;
			logic [7:0] cnt_reg, btime;
			logic start, immed;
			assign start = gi == 0 ? rise_ev : fall_ev;
			assign btime = gi == 0 ? cfg_i.rising_blank_time
				: cfg_i.falling_blank_time;
			assign immed = (gi == 0 ? cfg_i.rising_blank_mode
				: cfg_i.falling_blank_mode) == BLANK_IMMED;
			assign blank_on[gi] = state_reg == BLANK_RUN;
			always_ff @(posedge clk_sys_i or posedge reset_i) begin
				if (reset_i) begin
					state_reg <= BLANK_IDLE;
					cnt_reg <= BLANK_CNT_RESET;
				end else if (!en || !immed) begin
					state_reg <= BLANK_IDLE;
					cnt_reg <= BLANK_CNT_RESET;
				end else if (start) begin
					state_reg <= BLANK_RUN;
					cnt_reg <= BLANK_CNT_RESET;
				end else if (tick) begin
					case (state_reg)
						BLANK_RUN: begin
							if (cnt_reg == btime) begin
								state_reg <= BLANK_IDLE;
							end else begin
								cnt_reg <= cnt_reg + 8'h01;
							end
						end
						default: state_reg <= BLANK_IDLE;
					endcase
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			blanking_o <= 2'h0;
		end else begin
			blanking_o <= blank_on;
		end
	end

	// =========================================================
	// staged byte registers and double buffer transfer
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			staged_reg <= {VALUE_RESET, VALUE_RESET, VALUE_RESET};
		end else if (value_wr_i) begin
			case (value_sel_i)
				VSEL_PERIOD_LOW: staged_reg.period[7:0] <= value_byte_i;
				VSEL_PERIOD_HIGH: staged_reg.period[15:8] <= value_byte_i;
				VSEL_PHASE_LOW: staged_reg.phase[7:0] <= value_byte_i;
				VSEL_PHASE_HIGH: staged_reg.phase[15:8] <= value_byte_i;
				VSEL_DUTY_LOW: staged_reg.duty[7:0] <= value_byte_i;
				VSEL_DUTY_HIGH: staged_reg.duty[15:8] <= value_byte_i;
				default: staged_reg <= staged_reg;
			endcase
		end
	end
	assign staged_values_o = staged_reg;

	// a new request in the transfer cycle stays pending
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			load_pending_reg <= 1'b0;
			active_reg <= {VALUE_RESET, VALUE_RESET, VALUE_RESET};
		end else begin
			if (buffer_load_request_i) begin
				load_pending_reg <= 1'b1;
			end else if (per_ev && load_pending_reg) begin
				load_pending_reg <= 1'b0;
			end
			if (per_ev && load_pending_reg) begin
				active_reg <= staged_reg;
			end
		end
	end
	assign buffer_load_request_o = load_pending_reg;
	assign timebase_counter_o = counter_reg;

	// =========================================================
	// interrupt flags, summary and gated request
	assign hw_flags = {per_match, dc_match, ph_match, ovf_ev};

	// set beats a same-cycle clear; disabling wipes local flags only
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			flags_reg <= FLAGS_RESET;
		end else if (!en) begin
			flags_reg <= FLAGS_RESET;
		end else begin
			flags_reg <= (flags_reg & ~flag_clr_i) | hw_flags
				| flag_set_i;
		end
	end
	assign irq_flags_o = flags_reg;

	// summary re-arms while any enabled local flag is still set
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			timebase_summary_flag_o <= 1'b0;
			irq_o <= 1'b0;
		end else begin
			if (|(flags_reg & cfg_i.irq_enables)) begin
				timebase_summary_flag_o <= 1'b1;
			end else if (summary_clr_i) begin
				timebase_summary_flag_o <= 1'b0;
			end
			irq_o <= timebase_summary_flag_o && timebase_summary_enable_i
				&& peripheral_global_enable_i
				&& global_irq_enable_i;
		end
	end

	// =========================================================
	// assertions
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);

	counter_restart_a: assert property (per_ev |=> counter_reg == COUNTER_RESET)
		else $error("counter not reset after period event");
	period_match_a: assert property (per_match
		&& cfg_i.period_sources[SRC_TIMEBASE] |=> period_event_o)
		else $error("period match gave no period event");
	match_flags_a: assert property (per_match && ph_match && dc_match
		|=> flags_reg[3:1] == 3'h7 || !en)
		else $error("match flags not set");
	overflow_flag_a: assert property (ovf_ev |=> flags_reg[FLAG_OVF] || !en)
		else $error("overflow flag missing");
	disable_clear_a: assert property (!en |=> counter_reg == COUNTER_RESET
		&& flags_reg == FLAGS_RESET)
		else $error("disable left counter or flags");
	load_transfer_a: assert property (per_ev && load_pending_reg
		|=> active_reg == $past(staged_reg))
		else $error("buffer transfer missed");
	zero_duty_a: assert property (rising_event_o && falling_event_o
		|-> !pwm_active_o)
		else $error("output active at zero duty");
	// irq follows the raised summary one cycle later, gated by all three enables
	summary_set_a: assert property (|(flags_reg & cfg_i.irq_enables)
		|=> timebase_summary_flag_o ##1 (irq_o == ($past(timebase_summary_enable_i)
		&& $past(peripheral_global_enable_i)
		&& $past(global_irq_enable_i))))
		else $error("summary flag not raised");
	irq_gate_a: assert property (irq_o |-> $past(timebase_summary_flag_o)
		&& $past(global_irq_enable_i))
		else $error("irq without enables");
	rise_after_fall_a: assert property (fall_done_reg && !per_ev
		|-> !rise_ev)
		else $error("rise after fall in one period");

	period_seen_c: cover property (per_ev ##[1:20] per_ev);
	zero_duty_c: cover property (rise_ev && fall_ev);
	overflow_c: cover property (ovf_ev);
	blanking_c: cover property (blank_on[0] ##1 !blank_on[0]);

endmodule
`default_nettype wire

// [verilog/timebase_pkg.sv]
// shared constants and carrier types for the pwm time base block
`default_nettype none
package timebase_pkg;

	// ==========================================================
	// widths
	localparam int CNT_W = 16;
	localparam int BLANK_W = 8;
	localparam int NUM_CMP = 4;
	localparam int NUM_ASYNC = 5;

	// ==========================================================
	// clock source, prescaler and blanking mode codes
	localparam logic [1:0] CSRC_SYSOSC = 2'h0;
	localparam logic [1:0] CSRC_FAST = 2'h1;
	localparam logic [1:0] CSRC_EXTPIN = 2'h2;
	localparam logic [1:0] BLANK_IMMED = 2'h1;
	localparam logic [2:0] DIV_RESET = 3'h0;

	// ==========================================================
	// reset values and counter limits
	localparam logic [15:0] COUNTER_RESET = 16'h0000;
	localparam logic [15:0] COUNTER_MAX = 16'hFFFF;
	localparam logic [15:0] VALUE_RESET = 16'h0000;
	localparam logic [7:0] BLANK_CNT_RESET = 8'h00;
	localparam logic [3:0] FLAGS_RESET = 4'h0;

	// ==========================================================
	// byte select codes for the value write port
	localparam logic [2:0] VSEL_PERIOD_LOW = 3'h0;
	localparam logic [2:0] VSEL_PERIOD_HIGH = 3'h1;
	localparam logic [2:0] VSEL_PHASE_LOW = 3'h2;
	localparam logic [2:0] VSEL_PHASE_HIGH = 3'h3;
	localparam logic [2:0] VSEL_DUTY_LOW = 3'h4;
	localparam logic [2:0] VSEL_DUTY_HIGH = 3'h5;

	// flag bit positions; source bit 0 is the time base match
	localparam int FLAG_OVF = 0;
	localparam int FLAG_PHASE = 1;
	localparam int FLAG_DUTY = 2;
	localparam int FLAG_PERIOD = 3;
	localparam int SRC_TIMEBASE = 0;

	typedef struct packed {
		logic [15:0] period;
		logic [15:0] phase;
		logic [15:0] duty;
	} match_values_t;

	typedef struct packed {
		logic module_enable_bit;
		logic [1:0] clock_source_select;
		logic [1:0] clock_divide_select;
		logic period_async_invert;
		logic falling_async_invert;
		logic [1:0] rising_blank_mode;
		logic [1:0] falling_blank_mode;
		logic [7:0] rising_blank_time;
		logic [7:0] falling_blank_time;
		logic [4:0] rising_blank_sources;
		logic [4:0] falling_blank_sources;
		logic [5:0] period_sources;
		logic [5:0] rising_sources;
		logic [5:0] falling_sources;
		logic [4:0] shutdown_sources;
		logic [3:0] irq_enables;
	} cfg_t;

	typedef enum logic {BLANK_IDLE, BLANK_RUN} blank_state_t;

endpackage
`default_nettype wire

// [verification/far_side_model.sv]
// behavioural comparators, event pin and oscillators beside the time base
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
	input wire logic clk_sys_i,
	input wire logic cmp_pulse_i,
	input wire logic pin_pulse_i,
	output logic [3:0] comparator_synced_out_o,
	output logic external_event_pin_o,
	output logic fast_osc_o,
	output logic ext_clk_o
);
	int cmp_left = 0;
	int pin_left = 0;
	// ======================================================
	// oscillators, free running and unrelated in phase to the bench clock
	initial begin
		comparator_synced_out_o = 4'h0;
		external_event_pin_o = 1'b0;
		fast_osc_o = 1'b0;
		ext_clk_o = 1'b0;
		fork
			forever #7.8 fast_osc_o = ~fast_osc_o;
			forever #12.1 ext_clk_o = ~ext_clk_o;
		join
	end
	// ======================================================
	// one request holds comparator 1 or the pin high for ten cycles;
	// the unselected comparators wander so a stray select would show
	always @(posedge clk_sys_i) begin
		cmp_left <= cmp_pulse_i ? 10 : (cmp_left > 0 ? cmp_left - 1 : 0);
		pin_left <= pin_pulse_i ? 10 : (pin_left > 0 ? pin_left - 1 : 0);
		comparator_synced_out_o <= {3'($urandom), 1'(cmp_left > 0)};
		// pin is asynchronous, so it moves away from the clock edge
		external_event_pin_o <= #1.3 (pin_left > 0);
	end
endmodule
`default_nettype wire

// [verification/tb_top.sv]
// self-checking bench for the pwm time base, events, flags and blanking
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import timebase_pkg::*;
	logic clk_sys_i, reset_i, sleep_i, fast_osc_i, ext_clk_i;
	logic external_event_pin_i, value_wr_i, buffer_load_request_i;
	logic summary_clr_i, timebase_summary_enable_i, irq_o;
	logic peripheral_global_enable_i, global_irq_enable_i;
	logic cmp_pulse, pin_pulse, period_event_o, rising_event_o;
	logic falling_event_o, pwm_active_o, shutdown_request_o;
	logic buffer_load_request_o, timebase_summary_flag_o;
	logic [3:0] comparator_synced_out_i, flag_set_i, flag_clr_i, irq_flags_o;
	logic [2:0] value_sel_i;
	logic [7:0] value_byte_i;
	logic [15:0] timebase_counter_o;
	logic [1:0] blanking_o;
	cfg_t cfg_i;
	match_values_t staged_values_o;
	int bad_count = 0, check_count = 0, model_on = 0, exp_cnt, exp_pe, mper;
	int per, n_pe, n_act, n_fall, n_blank, n_shut, ph_t[4], dc_t[4], act_t[4];

	pwm_timebase_event_blanking u_pwm_timebase_event_blanking (
		.clk_sys_i, .reset_i, .cfg_i, .sleep_i, .fast_osc_i, .ext_clk_i,
		.external_event_pin_i, .comparator_synced_out_i, .value_wr_i,
		.value_sel_i, .value_byte_i, .buffer_load_request_i, .flag_set_i,
		.flag_clr_i, .summary_clr_i, .timebase_summary_enable_i,
		.peripheral_global_enable_i, .global_irq_enable_i,
		.timebase_counter_o, .staged_values_o, .buffer_load_request_o,
		.period_event_o, .rising_event_o, .falling_event_o, .pwm_active_o,
		.shutdown_request_o, .blanking_o, .irq_flags_o,
		.timebase_summary_flag_o, .irq_o);
	far_side_model u_far_side_model (.clk_sys_i, .cmp_pulse_i(cmp_pulse),
		.pin_pulse_i(pin_pulse),
		.comparator_synced_out_o(comparator_synced_out_i),
		.external_event_pin_o(external_event_pin_i),
		.fast_osc_o(fast_osc_i), .ext_clk_o(ext_clk_i));

	// ======================================================
	// shared tasks
	task automatic check(input string what, input logic [47:0] seen,
		input logic [47:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// count pulses and levels over n cycles, starting with the current one
	task automatic window(input int n);
		n_pe = 0;
		n_act = 0;
		n_fall = 0;
		n_blank = 0;
		n_shut = 0;
		repeat (n) begin
			n_pe += (period_event_o === 1'b1);
			n_act += (pwm_active_o === 1'b1);
			n_fall += (falling_event_o === 1'b1);
			n_blank += (blanking_o[0] === 1'b1);
			n_shut += (shutdown_request_o === 1'b1);
			@(negedge clk_sys_i);
		end
	endtask

	// bounded wait for a period (0) or rising (1) event pulse
	task automatic wait_for(input int what);
		int i;
		i = 0;
		do begin
			@(negedge clk_sys_i);
			i++;
		end while ((what ? rising_event_o : period_event_o) !== 1'b1 && i < 300);
		if (i >= 300) check("event wait", 48'h0, 48'h1);
	endtask

	task automatic pulse(input int pin);
		@(posedge clk_sys_i);
		if (pin) pin_pulse <= 1'b1;
		else cmp_pulse <= 1'b1;
		@(posedge clk_sys_i);
		cmp_pulse <= 1'b0;
		pin_pulse <= 1'b0;
		// hand back on a settled edge so a following window never races
		@(negedge clk_sys_i);
	endtask

	// byte writes, one refused select, then an optional buffered load
	task automatic load_vals(input int p, ph, dc, input bit ld);
		logic [15:0] w [3];
		w = '{16'(p), 16'(ph), 16'(dc)};
		for (int k = 0; k < 6; k++) begin
			@(posedge clk_sys_i);
			value_wr_i <= 1'b1;
			value_sel_i <= 3'(k);
			value_byte_i <= w[k / 2][(k % 2) * 8 +: 8];
		end
		@(posedge clk_sys_i);
		value_sel_i <= 3'h6;
		value_byte_i <= 8'($urandom);
		@(posedge clk_sys_i);
		value_wr_i <= 1'b0;
		@(negedge clk_sys_i);
		check("staged", staged_values_o, {w[0], w[1], w[2]});
		if (ld) begin
			@(posedge clk_sys_i);
			buffer_load_request_i <= 1'b1;
			@(posedge clk_sys_i);
			buffer_load_request_i <= 1'b0;
			@(negedge clk_sys_i);
			check("pending", buffer_load_request_o, 1);
			wait_for(0);
			wait_for(0);
			check("loaded", buffer_load_request_o, 0);
		end
	endtask

	// run the counter model for n cycles from a period event
	task automatic sync_model(input int p, input int n);
		mper = p;
		wait_for(0);
		exp_pe = (p == 0);
		exp_cnt = exp_pe ? 0 : 1;
		#1 model_on = 1;
		repeat (n) @(negedge clk_sys_i);
		model_on = 0;
	endtask

	// ======================================================
	// reference model of counter and period pulse, time base source only
	always @(negedge clk_sys_i) begin
		if (model_on) begin
			check("counter", timebase_counter_o, exp_cnt);
			check("period event", period_event_o, exp_pe);
			exp_pe = (exp_cnt == mper);
			exp_cnt = exp_pe ? 0 : exp_cnt + 1;
		end
	end

	initial begin
		clk_sys_i = 1'b0;
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end

	// hang guard, well past the expected run length
	initial begin
		#450000;
		bad_count++;
		report_and_stop();
	end

	// ======================================================
	// main sequence
	initial begin
		void'($urandom(69996));
		reset_i = 1'b1;
		sleep_i = 1'b0;
		value_wr_i = 1'b0;
		value_sel_i = 3'h0;
		value_byte_i = 8'h00;
		buffer_load_request_i = 1'b0;
		flag_set_i = 4'h0;
		flag_clr_i = 4'h0;
		summary_clr_i = 1'b0;
		timebase_summary_enable_i = 1'b0;
		peripheral_global_enable_i = 1'b0;
		global_irq_enable_i = 1'b0;
		cmp_pulse = 1'b0;
		pin_pulse = 1'b0;
		cfg_i = '0;
		cfg_i.module_enable_bit = 1'b1;
		cfg_i.period_sources = 6'h01;
		cfg_i.rising_sources = 6'h01;
		cfg_i.falling_sources = 6'h01;
		repeat (10) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		@(negedge clk_sys_i);
		check("reset outputs", {timebase_counter_o, irq_flags_o, irq_o}, 0);
		per = 8 + $urandom % 24;
		ph_t = '{0, 3, 6, 0};
		dc_t = '{0, 3, 2, 65535};
		ph_t[0] = $urandom % 4;
		dc_t[0] = ph_t[0] + 1 + $urandom % 4;
		act_t = '{dc_t[0] - ph_t[0], 0, 0, per + 1};
		// staged values must not act before a load request
		load_vals(per, ph_t[0], dc_t[0], 1'b0);
		sync_model(0, 20);
		// normal, zero duty, fall before rise, full duty
		for (int c = 0; c < 4; c++) begin
			load_vals(per, ph_t[c], dc_t[c], 1'b1);
			sync_model(per, 2 * per + 2);
			window(per + 1);
			check("active", n_act, act_t[c]);
			check("falls", n_fall, c == 3 ? 0 : 1);
			if (c == 0) begin
				check("match flags", irq_flags_o[3:1], 3'h7);
				check("summary idle", timebase_summary_flag_o, 0);
			end
		end
		// flags: clear, software set, gating, disable
		@(posedge clk_sys_i);
		flag_clr_i <= 4'hF;
		summary_clr_i <= 1'b1;
		@(posedge clk_sys_i);
		flag_clr_i <= 4'h0;
		summary_clr_i <= 1'b0;
		cfg_i.irq_enables <= 4'h4;
		timebase_summary_enable_i <= 1'b1;
		peripheral_global_enable_i <= 1'b1;
		global_irq_enable_i <= 1'b1;
		repeat (4) @(negedge clk_sys_i);
		check("unenabled", {irq_flags_o[2], timebase_summary_flag_o}, 0);
		@(posedge clk_sys_i);
		flag_set_i <= 4'h4;
		@(posedge clk_sys_i);
		flag_set_i <= 4'h0;
		repeat (3) @(negedge clk_sys_i);
		check("soft irq", {irq_flags_o[2], timebase_summary_flag_o, irq_o}, 7);
		@(posedge clk_sys_i);
		global_irq_enable_i <= 1'b0;
		repeat (3) @(negedge clk_sys_i);
		check("gated", {timebase_summary_flag_o, irq_o}, 2);
		@(posedge clk_sys_i);
		cfg_i.module_enable_bit <= 1'b0;
		repeat (3) @(negedge clk_sys_i);
		check("disabled", {irq_flags_o, timebase_summary_flag_o,
			timebase_counter_o}, 48'h10000);
		@(posedge clk_sys_i);
		cfg_i.module_enable_bit <= 1'b1;
		// prescaler stretches each period
		load_vals(3, 1, 2, 1'b1);
		for (int d = 0; d < 4; d++) begin
			@(posedge clk_sys_i);
			cfg_i.clock_divide_select <= 2'(d);
			wait_for(0);
			wait_for(0);
			window(16 << d);
			check("divided", n_pe, 4);
		end
		// clock sources while asleep
		@(posedge clk_sys_i);
		cfg_i.clock_divide_select <= 2'h0;
		sleep_i <= 1'b1;
		for (int s = 0; s < 4; s++) begin
			@(posedge clk_sys_i);
			cfg_i.clock_source_select <= 2'(s);
			repeat (10) @(negedge clk_sys_i);
			window(100);
			check("asleep", n_pe > 0, s == 1 || s == 2);
		end
		@(posedge clk_sys_i);
		sleep_i <= 1'b0;
		cfg_i.clock_source_select <= 2'h0;
		// asynchronous period sources, both polarities, then the pin
		load_vals(60, 5, 30, 1'b1);
		for (int i = 0; i < 3; i++) begin
			@(posedge clk_sys_i);
			cfg_i.period_sources <= i == 2 ? 6'h20 : 6'h02;
			cfg_i.period_async_invert <= (i == 1);
			cfg_i.shutdown_sources <= 5'h01;
			repeat (4) @(negedge clk_sys_i);
			pulse(i == 2);
			window(9);
			check("lead edge", n_pe, i != 1);
			if (i == 0) check("shutdown", n_shut > 0, 1);
			window(12);
			check("trail edge", n_pe, i == 1);
		end
		// rising blanking across all mode codes
		@(posedge clk_sys_i);
		cfg_i.period_sources <= 6'h03;
		cfg_i.period_async_invert <= 1'b0;
		cfg_i.rising_blank_sources <= 5'h01;
		cfg_i.rising_blank_time <= 8'h0C;
		for (int m = 0; m < 4; m++) begin
			@(posedge clk_sys_i);
			cfg_i.rising_blank_mode <= 2'(m);
			wait_for(0);
			wait_for(1);
			fork
				window(16);
				pulse(0);
			join
			check("blank", n_blank, m == 1 ? 13 : 0);
			check("blanked", n_pe, m != 1);
		end
		// free run with no period source must roll over
		@(posedge clk_sys_i);
		cfg_i.period_sources <= 6'h00;
		flag_clr_i <= 4'h1;
		@(posedge clk_sys_i);
		flag_clr_i <= 4'h0;
		repeat (65540) @(negedge clk_sys_i);
		check("overflow", irq_flags_o[FLAG_OVF], 1);
		report_and_stop();
	end
endmodule
`default_nettype wire
